// ### verilog/pdsp_decoder.sv
`timescale 1ns/1ps
`include "pdsp_regs.svh"
module pdsp_decoder
    import pdsp_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_reset_n_pin,
    // Oscillator
    input wire logic i_oscillator_in,
    output logic o_oscillator_out,
    output logic o_half_rate_clock_out,
    // Receiver side
    input wire logic i_symbol_msb_in,
    input wire logic i_symbol_lsb_in,
    input wire logic [7:0] i_rx_ctrl,
    input wire logic i_rx_ctrl_oe_n,
    output logic [7:0] o_rx_ctrl,
    output logic [7:0] o_rx_ctrl_oe_n,
    output logic [1:0] o_symbol,
    // Packet user side
    input wire logic i_tx_valid,
    input wire pdsp_pkt_t i_tx_pkt,
    output logic o_tx_taken,
    output logic o_rx_valid,
    output pdsp_pkt_t o_rx_pkt,
    output logic o_enabled,
    // Serial link
    pdsp_if.decoder link
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [6:0] sync_out;
    logic ss_n_s, sck_s, mosi_s, rst_n_s, osc_s, sym1_s, sym0_s;

    pdsp_sync #(.WIDTH(7)) u_sync (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_async({link.ss_n, link.sck, link.mosi, i_reset_n_pin, i_oscillator_in,
                  i_symbol_msb_in, i_symbol_lsb_in}),
        .o_sync(sync_out)
    );
    assign {ss_n_s, sck_s, mosi_s, rst_n_s, osc_s, sym1_s, sym0_s} = sync_out;

    // ************************************************************
    // State
    // ************************************************************
    pdsp_state_t state_q, state_d;
    logic ss_n_q, ss_n_d, sck_q, sck_d, osc_q, osc_d;
    logic [`PDSP_CNT_BITS-1:0] cnt_q, cnt_d;
    pdsp_pkt_t sh_out_q, sh_out_d, sh_in_q, sh_in_d;
    logic [`PDSP_INFO_BITS-1:0] cksum_q, cksum_d;
    logic en_q, en_d;
    logic pend_q, pend_d;
    pdsp_pkt_t pend_pkt_q, pend_pkt_d;
    logic miso_q, miso_d, miso_oe_n_q, miso_oe_n_d, ready_n_q, ready_n_d;
    logic taken_q, taken_d, rxv_q, rxv_d, half_q, half_d;
    pdsp_pkt_t rx_pkt_q, rx_pkt_d;
    logic [7:0] rxc_q, rxc_d, rxc_oe_n_q, rxc_oe_n_d;
    logic [1:0] sym_q, sym_d;
    logic soft_rst;
    logic [`PDSP_ID_BITS-1:0] in_id;
    pdsp_pkt_t full_in;

    // Pin reset acts as a synchronous reset of the whole port except the input synchronisers, which only i_reset clears
    assign soft_rst = i_reset | ~rst_n_s;
    assign full_in = {sh_in_q[`PDSP_PKT_BITS-2:0], mosi_s};
    assign in_id = full_in[`PDSP_ID_MSB:`PDSP_ID_LSB];

    always_comb begin
        state_d = state_q;
        ss_n_d = ss_n_s;
        sck_d = sck_s;
        osc_d = osc_s;
        cnt_d = cnt_q;
        sh_out_d = sh_out_q;
        sh_in_d = sh_in_q;
        cksum_d = cksum_q;
        en_d = en_q;
        pend_d = pend_q;
        pend_pkt_d = pend_pkt_q;
        miso_d = miso_q;
        ready_n_d = ready_n_q;
        taken_d = 1'b0;
        rxv_d = 1'b0;
        rx_pkt_d = rx_pkt_q;
        // Decoder never drives sck; only sampled here
        half_d = (osc_s & ~osc_q) ? ~half_q : half_q;
        sym_d = {sym1_s, sym0_s};
        rxc_d = i_rx_ctrl;
        rxc_oe_n_d = {8{i_rx_ctrl_oe_n}};
        miso_oe_n_d = ss_n_s;
        if (i_tx_valid && !pend_q) begin
            pend_d = 1'b1;
            pend_pkt_d = i_tx_pkt;
            taken_d = 1'b1;
        end
        unique case (state_q)
            PDSP_IDLE: begin
                ready_n_d = 1'b1;
                // Queued packet pulls ready low while enabled, even while deselected
                if (pend_q && en_q) begin
                    ready_n_d = 1'b0;
                end
                if (ss_n_q && !ss_n_s) begin
                    state_d = PDSP_SHIFT;
                end else if (!ss_n_s && pend_q && en_q) begin
                    state_d = PDSP_SHIFT;
                end
                if (state_d == PDSP_SHIFT) begin
                    cnt_d = '0;
                    // Withheld output still answers with a valid packet
                    if (pend_q && en_q) begin
                        sh_out_d = pend_pkt_q;
                        pend_d = 1'b0;
                    end else if (en_q) begin
                        sh_out_d = {`PDSP_ID_STATUS, `PDSP_CKSUM_RST};
                    end else begin
                        sh_out_d = {`PDSP_ID_PART, `PDSP_CKSUM_RST};
                    end
                    miso_d = sh_out_d[`PDSP_PKT_BITS-1];
                    ready_n_d = 1'b0;
                end
            end
            PDSP_SHIFT: begin
                if (ss_n_s) begin
                    // Deselect mid-packet abandons it
                    state_d = PDSP_IDLE;
                    ready_n_d = 1'b1;
                end else if (sck_s && !sck_q) begin
                    sh_in_d = full_in;
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == `PDSP_CNT_BITS'(`PDSP_PKT_BITS - 1)) begin
                        state_d = PDSP_DONE;
                        ready_n_d = 1'b1;
                        rxv_d = 1'b1;
                        rx_pkt_d = full_in;
                        if (in_id == `PDSP_ID_CHECKSUM) begin
                            en_d = (full_in[`PDSP_INFO_MSB:0] == cksum_q);
                        end else begin
                            en_d = 1'b0;
                            if (in_id < `PDSP_ID_SPECIAL_LO || in_id > `PDSP_ID_SPECIAL_HI) begin
                                cksum_d = cksum_q ^ full_in[`PDSP_INFO_MSB:0];
                            end
                        end
                    end
                end else if (!sck_s && sck_q) begin
                    sh_out_d = {sh_out_q[`PDSP_PKT_BITS-2:0], 1'b0};
                    miso_d = sh_out_q[`PDSP_PKT_BITS-2];
                end
            end
            PDSP_DONE: begin
                // Wait for last clock to fall before next packet
                if (!sck_s) begin
                    state_d = PDSP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (soft_rst) begin
            state_q <= PDSP_IDLE;
            ss_n_q <= 1'b1;
            sck_q <= 1'b0;
            osc_q <= 1'b0;
            cnt_q <= '0;
            sh_out_q <= '0;
            sh_in_q <= '0;
            cksum_q <= `PDSP_CKSUM_RST;
            en_q <= 1'b0;
            pend_q <= 1'b0;
            pend_pkt_q <= '0;
            miso_q <= 1'b0;
            miso_oe_n_q <= 1'b1;
            ready_n_q <= 1'b1;
            taken_q <= 1'b0;
            rxv_q <= 1'b0;
            rx_pkt_q <= '0;
            half_q <= 1'b0;
            sym_q <= '0;
            rxc_q <= `PDSP_RXCTRL_RST;
            rxc_oe_n_q <= 8'hff;
        end else begin
            state_q <= state_d;
            ss_n_q <= ss_n_d;
            sck_q <= sck_d;
            osc_q <= osc_d;
            cnt_q <= cnt_d;
            sh_out_q <= sh_out_d;
            sh_in_q <= sh_in_d;
            cksum_q <= cksum_d;
            en_q <= en_d;
            pend_q <= pend_d;
            pend_pkt_q <= pend_pkt_d;
            miso_q <= miso_d;
            miso_oe_n_q <= miso_oe_n_d;
            ready_n_q <= ready_n_d;
            taken_q <= taken_d;
            rxv_q <= rxv_d;
            rx_pkt_q <= rx_pkt_d;
            half_q <= half_d;
            sym_q <= sym_d;
            rxc_q <= rxc_d;
            rxc_oe_n_q <= rxc_oe_n_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.miso = miso_q;
    assign link.miso_oe_n = miso_oe_n_q;
    assign link.ready_n = ready_n_q;
    assign o_oscillator_out = osc_q;
    assign o_half_rate_clock_out = half_q;
    assign o_rx_ctrl = rxc_q;
    assign o_rx_ctrl_oe_n = rxc_oe_n_q;
    assign o_symbol = sym_q;
    assign o_tx_taken = taken_q;
    assign o_rx_valid = rxv_q;
    assign o_rx_pkt = rx_pkt_q;
    assign o_enabled = en_q;
endmodule

// ### common/pdsp_regs.svh
`ifndef PDSP_REGS_SVH
`define PDSP_REGS_SVH

// ************************************************************
// Packet layout
// ************************************************************
`define PDSP_PKT_BITS 32
`define PDSP_ID_BITS 8
`define PDSP_INFO_BITS 24
`define PDSP_ID_MSB 31
`define PDSP_ID_LSB 24
`define PDSP_INFO_MSB 23
`define PDSP_CNT_BITS 6

// ************************************************************
// Packet identifiers
// ************************************************************
`define PDSP_ID_CHECKSUM 8'h00
`define PDSP_ID_SPECIAL_LO 8'h1c
`define PDSP_ID_SPECIAL_HI 8'h1f
`define PDSP_ID_STATUS 8'h7f
`define PDSP_ID_PART 8'hff

// ************************************************************
// Reset values
// ************************************************************
`define PDSP_CKSUM_RST 24'h000000
`define PDSP_RXCTRL_RST 8'h00

`endif

// ### common/pdsp_pkg.sv
package pdsp_pkg;
    typedef logic [31:0] pdsp_pkt_t;
    typedef enum logic [1:0] {
        PDSP_IDLE,
        PDSP_SHIFT,
        PDSP_DONE
    } pdsp_state_t;
endpackage

// ### common/pdsp_if.sv
`timescale 1ns/1ps
interface pdsp_if;
    logic ss_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe_n;
    logic ready_n;
    modport decoder (
        input ss_n,
        input sck,
        input mosi,
        output miso,
        output miso_oe_n,
        output ready_n
    );
    modport host (
        output ss_n,
        output sck,
        output mosi,
        input miso,
        input miso_oe_n,
        input ready_n
    );
endinterface

// ### verilog/pdsp_sync.sv
`timescale 1ns/1ps
module pdsp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;
endmodule

// ### verilog/pdsp_host.sv
`timescale 1ns/1ps
`include "pdsp_regs.svh"
module pdsp_host
    import pdsp_pkg::*;
#(
    parameter int HALF_SCK = 4
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // User side
    input wire logic i_send_valid,
    input wire pdsp_pkt_t i_send_pkt,
    output logic o_send_taken,
    output logic o_recv_valid,
    output pdsp_pkt_t o_recv_pkt,
    // Serial link
    pdsp_if.host link
);
    pdsp_state_t state_q, state_d;
    logic [1:0] sync_out;
    logic rdy_n_s, miso_s;
    logic [`PDSP_CNT_BITS-1:0] cnt_q, cnt_d;
    logic [7:0] div_q, div_d;
    pdsp_pkt_t out_q, out_d, in_q, in_d, rxp_q, rxp_d;
    logic ss_n_q, ss_n_d, sck_q, sck_d, rv_q, rv_d, tk_q, tk_d;
    logic tick;

    pdsp_sync #(.WIDTH(2)) u_sync (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_async({link.ready_n, link.miso}),
        .o_sync(sync_out)
    );
    assign {rdy_n_s, miso_s} = sync_out;
    assign tick = (div_q == 8'(HALF_SCK - 1));

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        div_d = tick ? 8'h00 : div_q + 8'h01;
        out_d = out_q;
        in_d = in_q;
        rxp_d = rxp_q;
        ss_n_d = ss_n_q;
        sck_d = sck_q;
        rv_d = 1'b0;
        tk_d = 1'b0;
        unique case (state_q)
            PDSP_IDLE: begin
                if (tick && (i_send_valid || !rdy_n_s)) begin
                    // Idle host answers a read with a zero checksum packet
                    out_d = i_send_valid ? i_send_pkt : {`PDSP_ID_CHECKSUM, `PDSP_CKSUM_RST};
                    tk_d = i_send_valid;
                    ss_n_d = 1'b0;
                    cnt_d = '0;
                    state_d = PDSP_SHIFT;
                end
            end
            PDSP_SHIFT: begin
                // Clock only after decoder signals ready
                if (tick && !rdy_n_s || tick && sck_q) begin
                    sck_d = ~sck_q;
                    if (!sck_q) begin
                        cnt_d = cnt_q + 1'b1;
                    end else begin
                        // Sample late: a new bit needs five cycles through both synchronisers
                        in_d = {in_q[`PDSP_PKT_BITS-2:0], miso_s};
                        out_d = {out_q[`PDSP_PKT_BITS-2:0], 1'b0};
                        if (cnt_q == `PDSP_CNT_BITS'(`PDSP_PKT_BITS)) begin
                            state_d = PDSP_DONE;
                            rv_d = 1'b1;
                            rxp_d = in_d;
                        end
                    end
                end
            end
            PDSP_DONE: begin
                if (tick) begin
                    ss_n_d = 1'b1;
                    state_d = PDSP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_q <= PDSP_IDLE;
            cnt_q <= '0;
            div_q <= '0;
            out_q <= '0;
            in_q <= '0;
            rxp_q <= '0;
            ss_n_q <= 1'b1;
            sck_q <= 1'b0;
            rv_q <= 1'b0;
            tk_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            out_q <= out_d;
            in_q <= in_d;
            rxp_q <= rxp_d;
            ss_n_q <= ss_n_d;
            sck_q <= sck_d;
            rv_q <= rv_d;
            tk_q <= tk_d;
        end
    end

    assign link.ss_n = ss_n_q;
    assign link.sck = sck_q;
    assign link.mosi = out_q[`PDSP_PKT_BITS-1];
    assign o_send_taken = tk_q;
    assign o_recv_valid = rv_q;
    assign o_recv_pkt = rxp_q;
endmodule

// ### verification/pdsp_chk.sv
`timescale 1ns/1ps
// ********************
// Link checks
// ********************
module pdsp_chk (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Link
    input wire logic ss_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n,
    input wire logic ready_n
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    logic sck_q;
    logic sck_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    // Rising edges of the serial clock within one select
    always_comb begin
        sck_d = sck;
        cnt_d = cnt_q;
        if (ss_n) begin
            cnt_d = 8'h00;
        end else if (sck && !sck_q) begin
            cnt_d = cnt_q + 8'h01;
        end
    end
    always_ff @(posedge i_core_clk) begin
        sck_q <= i_reset ? 1'b0 : sck_d;
        cnt_q <= i_reset ? 8'h00 : cnt_d;
    end
    property p_len;
        $rose(ss_n) |-> cnt_q != 8'h00 && cnt_q[4:0] == 5'h00;
    endproperty
    a_len: assert property (p_len) else $error("select dropped off a packet boundary");
    property p_idle_sck;
        ss_n |-> !sck;
    endproperty
    a_idle_sck: assert property (p_idle_sck) else $error("serial clock high while deselected");
    property p_wait_rdy;
        $fell(ss_n) |-> (!sck throughout (##[0:20] !ready_n));
    endproperty
    a_wait_rdy: assert property (p_wait_rdy) else $error("clocked before ready");
    property p_rise_rdy;
        $rose(sck) |-> !ready_n && !ss_n;
    endproperty
    a_rise_rdy: assert property (p_rise_rdy) else $error("bit clocked while not ready");
    property p_high;
        $rose(sck) |=> sck[*3];
    endproperty
    a_high: assert property (p_high) else $error("serial clock high phase short");
    property p_low;
        $fell(sck) |=> !sck[*3];
    endproperty
    a_low: assert property (p_low) else $error("serial clock low phase short");
    property p_oe_off;
        ss_n[*4] |-> miso_oe_n;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("data out driven while deselected");
    property p_oe_on;
        !ss_n[*4] |-> !miso_oe_n;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("data out not driven while selected");
    property p_rel;
        $rose(sck) && cnt_q[4:0] == 5'h1f |-> ##[1:6] ready_n;
    endproperty
    a_rel: assert property (p_rel) else $error("ready not released after last bit");
    c_host: cover property ($fell(ss_n) && ready_n);
    c_dev: cover property ($fell(ready_n) && ss_n);
    c_b2b: cover property (cnt_q == 8'h40);
endmodule

// ### verification/pdsp_bench.sv
`timescale 1ns/1ps
module pdsp_bench;
    import pdsp_pkg::*;
    // ********************
    // Signals
    // ********************
    logic clk = 1'b0;
    logic rst, rst_pin_n, osc, sym_m, sym_l, rxc_oe_n, tx_v, snd_v, en_m;
    logic half, tx_tk, rx_v, en, snd_tk, rcv_v;
    logic [1:0] sym;
    logic [7:0] rxc, rxo, rxoe;
    pdsp_pkt_t tx_p, snd_p, rx_p, rcv_p, dec_rx, p;
    logic [31:0] rnd = 32'hd4c930c5;
    logic [23:0] cks;
    int failures = 0;
    int n_checks = 0;
    pdsp_if lnk ();
    always #12.5 clk = ~clk;
    pdsp_decoder pdsp_decoder_inst (.i_core_clk(clk), .i_reset(rst), .i_reset_n_pin(rst_pin_n),
        .i_oscillator_in(osc), .o_oscillator_out(), .o_half_rate_clock_out(half),
        .i_symbol_msb_in(sym_m), .i_symbol_lsb_in(sym_l), .i_rx_ctrl(rxc), .i_rx_ctrl_oe_n(rxc_oe_n),
        .o_rx_ctrl(rxo), .o_rx_ctrl_oe_n(rxoe), .o_symbol(sym), .i_tx_valid(tx_v), .i_tx_pkt(tx_p),
        .o_tx_taken(tx_tk), .o_rx_valid(rx_v), .o_rx_pkt(rx_p), .o_enabled(en), .link(lnk.decoder));
    pdsp_host pdsp_host_inst (.i_core_clk(clk), .i_reset(rst), .i_send_valid(snd_v), .i_send_pkt(snd_p),
        .o_send_taken(snd_tk), .o_recv_valid(rcv_v), .o_recv_pkt(rcv_p), .link(lnk.host));
    pdsp_chk pdsp_chk_inst (.i_core_clk(clk), .i_reset(rst), .ss_n(lnk.ss_n), .sck(lnk.sck),
        .mosi(lnk.mosi), .miso(lnk.miso), .miso_oe_n(lnk.miso_oe_n), .ready_n(lnk.ready_n));
    always @(posedge clk) if (rx_v === 1'b1) dec_rx <= rx_p;
    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic pdsp_pkt_t exp_back(input logic has_q, input pdsp_pkt_t q);
        return en_m ? (has_q ? q : 32'h7f000000) : 32'hff000000;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task chk_b(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task xfer(input pdsp_pkt_t pk, input logic has_q, input pdsp_pkt_t q);
        int i;
        pdsp_pkt_t exp;
        exp = exp_back(has_q, q);
        @(posedge clk);
        snd_p <= pk;
        snd_v <= 1'b1;
        i = 0;
        while (snd_tk !== 1'b1 && i < 2000) begin
            @(posedge clk);
            i++;
        end
        snd_v <= 1'b0;
        while (rcv_v !== 1'b1 && i < 4000) begin
            @(posedge clk);
            i++;
        end
        if (i >= 4000) begin
            failures++;
            $display("[ERR] %0t transfer timed out", $time);
        end
        chk(rcv_p, exp);
        repeat (8) @(posedge clk);
        chk(dec_rx, pk);
        if (pk[31:24] == 8'h00) begin
            en_m = (pk[23:0] == cks);
        end else begin
            en_m = 1'b0;
            if (pk[31:24] < 8'h1c || pk[31:24] > 8'h1f) cks = cks ^ pk[23:0];
        end
        chk_b(en, en_m);
    endtask
    task queue(input pdsp_pkt_t q);
        int i;
        @(posedge clk);
        tx_p <= q;
        tx_v <= 1'b1;
        i = 0;
        while (tx_tk !== 1'b1 && i < 100) begin
            @(posedge clk);
            i++;
        end
        tx_v <= 1'b0;
        chk_b(tx_tk, 1'b1);
    endtask
    task misc;
        logic h;
        rnd = lfsr(rnd);
        h = half;
        @(posedge clk);
        osc <= 1'b1;
        sym_m <= rnd[0];
        sym_l <= rnd[1];
        rxc <= rnd[9:2];
        rxc_oe_n <= rnd[10];
        repeat (6) @(posedge clk);
        osc <= 1'b0;
        chk_b(half, ~h);
        chk({30'h0, sym}, {30'h0, rnd[0], rnd[1]});
        chk({16'h0, rxoe, rxo}, {16'h0, {8{rnd[10]}}, rnd[9:2]});
    endtask
    task end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ********************
    // Sequence
    // ********************
    initial begin
        rst = 1'b1;
        rst_pin_n = 1'b1;
        {osc, sym_m, sym_l, rxc_oe_n, tx_v, snd_v, en_m} = '0;
        {rxc, tx_p, snd_p, cks} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        xfer(32'h00000000, 1'b0, '0);
        xfer(32'h00000000, 1'b0, '0);
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            p = rnd;
            if (k == 2) p[31:24] = 8'h1c;
            xfer(p, 1'b0, '0);
            xfer({8'h00, (k == 5) ? ~cks : cks}, 1'b0, '0);
            misc();
        end
        // Decoder-initiated packets, host answering with the running checksum cks
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            queue(rnd);
            xfer({8'h00, cks}, 1'b1, rnd);
        end
        @(posedge clk);
        rst_pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        cks = '0;
        en_m = 1'b0;
        chk_b(en, 1'b0);
        xfer(32'h00000000, 1'b0, '0);
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule
